// ### hw/thsm_edge_pick.sv
`timescale 1ns/1ps
// Captures each bit on both highway clock edges and returns the copy taken
// on the chosen edge: 1 picks the rising copy, 0 the falling copy.
module thsm_edge_pick #(
  parameter int W = 4
) (
  input wire logic clk_in,
  input wire logic [W-1:0] d_in,
  input wire logic [W-1:0] sel_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] rise_r;
  logic [W-1:0] fall_r;

  always_ff @(posedge clk_in) begin
    rise_r <= d_in;
  end

  always_ff @(negedge clk_in) begin
    fall_r <= d_in;
  end

  for (genvar i = 0; i < W; i++) begin : g_pick
    assign q_out[i] = sel_in[i] ? rise_r[i] : fall_r[i];
  end
endmodule

// ### hw/thsm_map.svh
`ifndef THSM_MAP_SVH
`define THSM_MAP_SVH
// Operation
// - Transmit data launches on falling clock edge when edge bit is 0, else rising.
// - Receive data is sampled on falling edge when edge bit is 0, else rising.
// - Transmit slot enable 1 drives the slot; 0 leaves the highway floating.
// - Receive slot enable 1 accepts data; 0 sends the idle code to the line.
// - Transmit select 0 uses the primary highway, 1 the secondary highway.
// - Receive select 0 takes the primary highway, 1 the secondary highway.
// - Transmit bit offset delays slot 0 by that many clock cycles after sync.
// - Receive bit offset delays slot 0 by that many clock cycles after sync.
// - Transmit byte offset shifts the frame by whole bytes, range set by rate.
// - Receive byte offset shifts the frame by whole bytes, range set by rate.
// - A frame is 64 bytes with signaling carry on, otherwise 32 bytes.
// - With signaling carry each slot is 16 bits: payload octet then signaling octet.
// - In T1 only, a 3-bit field places the eight stuffed slots.
// - A T1 frame holds 24 payload slots plus eight stuffed slots.
// - An E1 frame carries payload in all 32 slots.
// - A frame is one 8 kHz period of 32 contiguous slots.
// - Double slot mode alternates payload slots with floating, ignored slots.
// - Signaling carry in T1 keeps 24 plus eight stuffed two-octet slots.
// - Frame sync is sampled on falling edge when its bit is 0, else rising.
// - Rate field 00, 01, 10 select 2.048, 4.096, 8.192; 11 reserved.
// - Highway enable 0 sends idle to the line and floats the transmit highway.
`define THSM_IDX_STUFF 5'h00
`define THSM_IDX_SIGCARRY 5'h01
`define THSM_IDX_BITOFF 5'h02
`define THSM_IDX_TXBYTE 5'h03
`define THSM_IDX_RXBYTE 5'h04
`define THSM_IDX_TX_EN 5'h05
`define THSM_IDX_RX_EN 5'h09
`define THSM_IDX_TX_SEL 5'h0d
`define THSM_IDX_RX_SEL 5'h11
`define THSM_IDX_TX_ILV 5'h15
`define THSM_IDX_RX_ILV 5'h16
`define THSM_IDX_CTRL 5'h17
`define THSM_IDX_IDLE 5'h18
`define THSM_IDX_STATUS 5'h19
`define THSM_NUM_RW 25
`define THSM_REG_RESET 8'h00
`define THSM_SIG_BIT 2
`define THSM_TX_FS_EDGE_BIT 3
`define THSM_RX_FS_EDGE_BIT 7
`define THSM_CLK_EDGE_BIT 6
`define THSM_DTS_BIT 1
`define THSM_BYTE_HI_BIT 0
`define THSM_HWY_EN_BIT 7
`define THSM_RATE_HI_BIT 2
`define THSM_RATE_LO_BIT 3
`define THSM_T1_BIT 0
`define THSM_LAST_SLOT 5'h1f
`define THSM_T1_SLOTS 5'h18
`define THSM_LAST_BIT_NARROW 4'h7
`define THSM_LAST_BIT_WIDE 4'hf
`define THSM_GROUPED_STS 3'h4
`define THSM_MASK_2M 7'h1f
`define THSM_MASK_4M 7'h3f
`define THSM_MASK_8M 7'h7f
`endif

// ### hw/thsm_pkg.sv
`include "thsm_map.svh"
package thsm_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DLY, ST_RUN} thsm_st_type;

  typedef struct packed {
    thsm_st_type st;
    logic [10:0] cnt;
    logic [3:0] bitn;
    logic [4:0] slot;
    logic gap;
    logic [15:0] sh;
  } thsm_eng_type;

  typedef struct packed {
    logic hwy_en;
    logic [1:0] rate;
    logic t1;
    logic sig;
    logic [2:0] sts;
    logic tx_dts;
    logic rx_dts;
    logic [2:0] tx_bit_off;
    logic [2:0] rx_bit_off;
    logic [6:0] tx_byte_off;
    logic [6:0] rx_byte_off;
    logic tx_launch_edge;
    logic rx_sample_edge;
    logic tx_sync_edge;
    logic rx_sync_edge;
    logic [31:0] tx_en;
    logic [31:0] tx_sel;
    logic [31:0] rx_sel;
  } thsm_cfg_type;

  typedef struct packed {
    logic [`THSM_NUM_RW-1:0][7:0] regs;
    thsm_cfg_type cfg;
    logic [7:0] rdata;
    logic [31:0][15:0] txbuf;
    logic req_s1, req_s2, req_s3;
    logic ack_tgl;
    logic [15:0] ack_word;
    logic rx_s1, rx_s2, rx_s3;
    logic [1:0] run_s1, run_s2;
    logic line_vld;
    logic [4:0] line_chan;
    logic [15:0] line_word;
  } thsm_sys_type;

  typedef struct packed {
    thsm_eng_type [1:0] eng;
    thsm_cfg_type s1, s2;
    logic rst_s1, rst_s2, ce_s1, ce_s2;
    logic [1:0] fs_prev;
    logic req_tgl;
    logic [4:0] req_chan;
    logic ack_s1, ack_s2, ack_s3;
    logic [15:0] pre_word, cur_word;
    logic rx_tgl;
    logic [4:0] rx_slot, rx_chan;
    logic rx_valid;
    logic [15:0] rx_word;
    logic pri_d, pri_oe, sec_d, sec_oe;
  } thsm_link_type;
endpackage

// ### hw/thsm_slot_mapper.sv
`timescale 1ns/1ps
`include "thsm_map.svh"

module thsm_slot_mapper (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic [4:0] reg_idx_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic line_tx_wr_in,
  input wire logic [4:0] line_tx_chan_in,
  input wire logic [15:0] line_tx_word_in,
  output logic line_rx_vld_out,
  output logic [4:0] line_rx_chan_out,
  output logic [15:0] line_rx_word_out,
  input wire logic highway_clock_in,
  input wire logic tx_frame_sync_in,
  input wire logic rx_frame_sync_in,
  input wire logic rx_highway_primary_in,
  input wire logic rx_highway_secondary_in,
  output logic tx_highway_primary_out,
  output logic tx_highway_primary_oe_out,
  output logic tx_highway_secondary_out,
  output logic tx_highway_secondary_oe_out
);

  thsm_pkg::thsm_sys_type sys_r;
  thsm_pkg::thsm_sys_type sys_nxt;
  thsm_pkg::thsm_link_type lnk_r;
  thsm_pkg::thsm_link_type lnk_nxt;
  logic [3:0] pin_q;
  logic [3:0] out_q;

  // Stuffed slots exist only in T1; codes 0 to 3 stuff every fourth slot
  // from that position, larger codes group them at the end of the frame.
  function automatic logic slot_stuffed(
    input logic t1,
    input logic [2:0] sts,
    input logic [4:0] slot
  );
    logic res;
    res = 1'b0;
    if (t1) begin
      if (sts >= `THSM_GROUPED_STS) begin
        res = (slot >= `THSM_T1_SLOTS);
      end else begin
        res = (slot[1:0] == sts[1:0]);
      end
    end
    return res;
  endfunction

  // Line channel carried by a highway slot; stuffed slots are skipped so
  // the 24 T1 channels pack into channel numbers 0 to 23.
  function automatic logic [4:0] slot_chan(
    input logic t1,
    input logic [2:0] sts,
    input logic [4:0] slot
  );
    logic [4:0] base;
    logic [4:0] res;
    base = {1'b0, slot[4:2], 1'b0} + {2'b00, slot[4:2]}
           + {3'b000, slot[1:0]};
    res = slot;
    if (t1 && sts < `THSM_GROUPED_STS) begin
      res = (slot[1:0] > sts[1:0]) ? base - 5'h01 : base;
    end
    return res;
  endfunction

  // Cycles from the sampled sync to the first bit of slot 0. The byte
  // offset is cut to the range that the rate allows; code 11 acts as 00.
  function automatic logic [10:0] start_delay(
    input logic [2:0] bit_off,
    input logic [6:0] byte_off,
    input logic [1:0] rate
  );
    logic [6:0] mask;
    unique case (rate)
      2'b01: mask = `THSM_MASK_4M;
      2'b10: mask = `THSM_MASK_8M;
      default: mask = `THSM_MASK_2M;
    endcase
    return {1'b0, byte_off & mask, 3'b000} + {8'h00, bit_off};
  endfunction

  // System clock side: registers, transmit payload store, handshakes.
  always_comb begin
    sys_nxt = sys_r;
    if (sys_rst_in) begin
      sys_nxt = '0;
      for (int i = 0; i < `THSM_NUM_RW; i++) begin
        sys_nxt.regs[i] = `THSM_REG_RESET;
      end
    end else if (ce_in) begin
      if (reg_wr_in && reg_idx_in < `THSM_NUM_RW) begin
        sys_nxt.regs[reg_idx_in] = reg_wdata_in;
      end
      if (reg_rd_in) begin
        if (reg_idx_in < `THSM_NUM_RW) begin
          sys_nxt.rdata = sys_r.regs[reg_idx_in];
        end else if (reg_idx_in == `THSM_IDX_STATUS) begin
          sys_nxt.rdata = {6'h00, sys_r.run_s2};
        end else begin
          sys_nxt.rdata = 8'h00;
        end
      end

      sys_nxt.cfg.hwy_en = sys_r.regs[`THSM_IDX_CTRL][`THSM_HWY_EN_BIT];
      sys_nxt.cfg.rate = {sys_r.regs[`THSM_IDX_CTRL][`THSM_RATE_HI_BIT],
                          sys_r.regs[`THSM_IDX_CTRL][`THSM_RATE_LO_BIT]};
      sys_nxt.cfg.t1 = sys_r.regs[`THSM_IDX_CTRL][`THSM_T1_BIT];
      sys_nxt.cfg.sig = sys_r.regs[`THSM_IDX_SIGCARRY][`THSM_SIG_BIT];
      sys_nxt.cfg.sts = sys_r.regs[`THSM_IDX_STUFF][2:0];
      sys_nxt.cfg.tx_dts = sys_r.regs[`THSM_IDX_TX_ILV][`THSM_DTS_BIT];
      sys_nxt.cfg.rx_dts = sys_r.regs[`THSM_IDX_RX_ILV][`THSM_DTS_BIT];
      sys_nxt.cfg.tx_bit_off = sys_r.regs[`THSM_IDX_BITOFF][2:0];
      sys_nxt.cfg.rx_bit_off = sys_r.regs[`THSM_IDX_BITOFF][6:4];
      sys_nxt.cfg.tx_sync_edge =
        sys_r.regs[`THSM_IDX_BITOFF][`THSM_TX_FS_EDGE_BIT];
      sys_nxt.cfg.rx_sync_edge =
        sys_r.regs[`THSM_IDX_BITOFF][`THSM_RX_FS_EDGE_BIT];
      sys_nxt.cfg.tx_byte_off =
        {sys_r.regs[`THSM_IDX_TX_ILV][`THSM_BYTE_HI_BIT],
         sys_r.regs[`THSM_IDX_TXBYTE][5:0]};
      sys_nxt.cfg.rx_byte_off =
        {sys_r.regs[`THSM_IDX_RX_ILV][`THSM_BYTE_HI_BIT],
         sys_r.regs[`THSM_IDX_RXBYTE][5:0]};
      sys_nxt.cfg.tx_launch_edge =
        sys_r.regs[`THSM_IDX_TXBYTE][`THSM_CLK_EDGE_BIT];
      sys_nxt.cfg.rx_sample_edge =
        sys_r.regs[`THSM_IDX_RXBYTE][`THSM_CLK_EDGE_BIT];
      for (int k = 0; k < 4; k++) begin
        sys_nxt.cfg.tx_en[8*k +: 8] = sys_r.regs[`THSM_IDX_TX_EN + k];
        sys_nxt.cfg.tx_sel[8*k +: 8] = sys_r.regs[`THSM_IDX_TX_SEL + k];
        sys_nxt.cfg.rx_sel[8*k +: 8] = sys_r.regs[`THSM_IDX_RX_SEL + k];
      end

      if (line_tx_wr_in) begin
        sys_nxt.txbuf[line_tx_chan_in] = line_tx_word_in;
      end

      // The link changes the channel number only with its request toggle, once a slot,
      // so reading it across the boundary after the toggle is safe.
      sys_nxt.req_s1 = lnk_r.req_tgl;
      sys_nxt.req_s2 = sys_r.req_s1;
      sys_nxt.req_s3 = sys_r.req_s2;
      if (sys_r.req_s2 ^ sys_r.req_s3) begin
        sys_nxt.ack_word = sys_r.txbuf[lnk_r.req_chan];
        sys_nxt.ack_tgl = ~sys_r.ack_tgl;
      end

      sys_nxt.rx_s1 = lnk_r.rx_tgl;
      sys_nxt.rx_s2 = sys_r.rx_s1;
      sys_nxt.rx_s3 = sys_r.rx_s2;
      sys_nxt.line_vld = 1'b0;
      if ((sys_r.rx_s2 ^ sys_r.rx_s3) && lnk_r.rx_valid) begin
        sys_nxt.line_vld = 1'b1;
        sys_nxt.line_chan = lnk_r.rx_chan;
        if (sys_r.cfg.hwy_en
            && sys_r.regs[`THSM_IDX_RX_EN + lnk_r.rx_slot[4:3]]
                         [lnk_r.rx_slot[2:0]]) begin
          sys_nxt.line_word = lnk_r.rx_word;
        end else begin
          sys_nxt.line_word = {sys_r.regs[`THSM_IDX_IDLE],
                               sys_r.regs[`THSM_IDX_IDLE]};
        end
      end

      sys_nxt.run_s1 = {lnk_r.eng[1].st == thsm_pkg::ST_RUN,
                        lnk_r.eng[0].st == thsm_pkg::ST_RUN};
      sys_nxt.run_s2 = sys_r.run_s1;
    end
  end

  always_ff @(posedge clk_in) begin
    sys_r <= sys_nxt;
  end

  // Pin sampling: both syncs and both data inputs on their chosen edges.
  thsm_edge_pick #(
    .W(4)
  ) u_pin_pick (
    .clk_in(highway_clock_in),
    .d_in({rx_highway_secondary_in, rx_highway_primary_in,
           rx_frame_sync_in, tx_frame_sync_in}),
    .sel_in({lnk_r.s2.rx_sample_edge, lnk_r.s2.rx_sample_edge,
             lnk_r.s2.rx_sync_edge, lnk_r.s2.tx_sync_edge}),
    .q_out(pin_q)
  );

  // Launch retiming: the falling copy leaves half a cycle after the link
  // register, the rising copy a full cycle later.
  thsm_edge_pick #(
    .W(4)
  ) u_out_pick (
    .clk_in(highway_clock_in),
    .d_in({lnk_r.sec_oe, lnk_r.sec_d, lnk_r.pri_oe, lnk_r.pri_d}),
    .sel_in({4{lnk_r.s2.tx_launch_edge}}),
    .q_out(out_q)
  );

  // Highway clock side. Configuration is quasi-static and crosses through
  // two flip-flops; software should change it only while the highway is
  // disabled, since bits of one field may land a cycle apart.
  always_comb begin
    thsm_pkg::thsm_eng_type eng;
    thsm_pkg::thsm_cfg_type c;
    logic [4:0] old_slot;
    logic [3:0] last_bit;
    logic fs_hit;
    logic dts;
    logic load;
    logic emit;
    logic rx_bit;
    logic act;
    logic [10:0] dly;
    eng = lnk_r.eng[0];
    c = lnk_r.s2;
    old_slot = 5'h00;
    fs_hit = 1'b0;
    dts = 1'b0;
    load = 1'b0;
    emit = 1'b0;
    act = 1'b0;
    dly = 11'h000;
    lnk_nxt = lnk_r;
    last_bit = c.sig ? `THSM_LAST_BIT_WIDE
                     : `THSM_LAST_BIT_NARROW;
    rx_bit = c.rx_sel[lnk_r.eng[1].slot] ? pin_q[3]
                                          : pin_q[2];
    if (lnk_r.rst_s2) begin
      lnk_nxt = '0;
    end else if (lnk_r.ce_s2) begin
      lnk_nxt.ack_s3 = lnk_r.ack_s2;
      if (lnk_r.ack_s2 ^ lnk_r.ack_s3) begin
        lnk_nxt.pre_word = sys_r.ack_word;
      end

      for (int d = 0; d < 2; d++) begin
        eng = lnk_r.eng[d];
        old_slot = eng.slot;
        load = 1'b0;
        emit = 1'b0;
        fs_hit = pin_q[d] & ~lnk_r.fs_prev[d];
        lnk_nxt.fs_prev[d] = pin_q[d];
        if (d == 0) begin
          dts = c.tx_dts;
          dly = start_delay(c.tx_bit_off, c.tx_byte_off,
                            c.rate);
        end else begin
          dts = c.rx_dts;
          dly = start_delay(c.rx_bit_off, c.rx_byte_off,
                            c.rate);
        end

        // A sync seen mid-frame restarts the frame, so a slipped
        // backplane realigns on the very next sync pulse.
        if (fs_hit) begin
          eng.st = thsm_pkg::ST_DLY;
          eng.cnt = dly;
        end else begin
          unique case (eng.st)
            thsm_pkg::ST_IDLE: begin
              eng.cnt = 11'h000;
            end
            thsm_pkg::ST_DLY: begin
              if (eng.cnt == 11'h000) begin
                eng.st = thsm_pkg::ST_RUN;
                eng.bitn = 4'h0;
                eng.slot = 5'h00;
                eng.gap = 1'b0;
                load = 1'b1;
              end else begin
                eng.cnt = eng.cnt - 11'h001;
              end
            end
            thsm_pkg::ST_RUN: begin
              if (d == 1 && !eng.gap) begin
                eng.sh = {eng.sh[14:0], rx_bit};
              end
              if (eng.bitn == last_bit) begin
                eng.bitn = 4'h0;
                emit = !eng.gap;
                if (dts && !eng.gap) begin
                  eng.gap = 1'b1;
                end else begin
                  eng.gap = 1'b0;
                  if (eng.slot == `THSM_LAST_SLOT) begin
                    eng.st = thsm_pkg::ST_IDLE;
                  end else begin
                    eng.slot = eng.slot + 5'h01;
                    load = 1'b1;
                  end
                end
              end else begin
                eng.bitn = eng.bitn + 4'h1;
              end
            end
            default: begin
              eng.st = thsm_pkg::ST_IDLE;
            end
          endcase
        end

        // Each slot start asks for the following slot's word, so the
        // answer has a whole slot to cross; slot 31 prefetches slot 0.
        if (d == 0 && load) begin
          lnk_nxt.cur_word = lnk_r.pre_word;
          lnk_nxt.req_tgl = ~lnk_r.req_tgl;
          lnk_nxt.req_chan = slot_chan(c.t1, c.sts, eng.slot + 5'h01);
        end

        if (d == 1 && emit) begin
          lnk_nxt.rx_tgl = ~lnk_r.rx_tgl;
          lnk_nxt.rx_slot = old_slot;
          lnk_nxt.rx_chan = slot_chan(c.t1, c.sts, old_slot);
          lnk_nxt.rx_valid = !slot_stuffed(c.t1, c.sts,
                                           old_slot);
          lnk_nxt.rx_word = c.sig ? eng.sh
                                  : {eng.sh[7:0], 8'h00};
        end
        lnk_nxt.eng[d] = eng;
      end

      act = c.hwy_en
            && lnk_r.eng[0].st == thsm_pkg::ST_RUN
            && !lnk_r.eng[0].gap
            && c.tx_en[lnk_r.eng[0].slot]
            && !slot_stuffed(c.t1, c.sts, lnk_r.eng[0].slot);
      lnk_nxt.pri_d = lnk_r.cur_word[~lnk_r.eng[0].bitn];
      lnk_nxt.sec_d = lnk_r.cur_word[~lnk_r.eng[0].bitn];
      lnk_nxt.pri_oe = act && !c.tx_sel[lnk_r.eng[0].slot];
      lnk_nxt.sec_oe = act && c.tx_sel[lnk_r.eng[0].slot];
    end

    lnk_nxt.rst_s1 = sys_rst_in;
    lnk_nxt.rst_s2 = lnk_r.rst_s1;
    lnk_nxt.ce_s1 = ce_in;
    lnk_nxt.ce_s2 = lnk_r.ce_s1;
    lnk_nxt.s1 = sys_r.cfg;
    lnk_nxt.s2 = lnk_r.s1;
    lnk_nxt.ack_s1 = sys_r.ack_tgl;
    lnk_nxt.ack_s2 = lnk_r.ack_s1;
  end

  always_ff @(posedge highway_clock_in) begin
    lnk_r <= lnk_nxt;
  end

  assign reg_rdata_out = sys_r.rdata;
  assign line_rx_vld_out = sys_r.line_vld;
  assign line_rx_chan_out = sys_r.line_chan;
  assign line_rx_word_out = sys_r.line_word;
  assign tx_highway_primary_out = out_q[0];
  assign tx_highway_primary_oe_out = out_q[1];
  assign tx_highway_secondary_out = out_q[2];
  assign tx_highway_secondary_oe_out = out_q[3];
endmodule

// ### verification/tb_tdm_highway_slot_mapper.sv
`timescale 1ns/1ps
module tb_tdm_highway_slot_mapper;
  localparam int DT = 11;
  localparam logic [8:0] TEN = 9'h0f5;
  localparam logic [8:0] TSEL = 9'h0f0;
  localparam logic [7:0] REN = 8'h0f;
  localparam logic [7:0] RSEL = 8'h0a;
  logic clk_in, sys_rst_in, ce_in, reg_wr_in, reg_rd_in;
  logic [4:0] reg_idx_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, rd_v;
  logic line_tx_wr_in, line_rx_vld_out;
  logic [4:0] line_tx_chan_in, line_rx_chan_out;
  logic [15:0] line_tx_word_in, line_rx_word_out;
  logic highway_clock_in, tx_frame_sync_in, rx_frame_sync_in;
  logic rx_highway_primary_in, rx_highway_secondary_in;
  logic tx_highway_primary_out, tx_highway_primary_oe_out;
  logic tx_highway_secondary_out, tx_highway_secondary_oe_out;
  wire pri_w;
  wire sec_w;
  int num_errors = 0;
  int n_checks = 0;
  logic [15:0] rxw [0:31];
  assign pri_w = tx_highway_primary_oe_out ? tx_highway_primary_out : 1'bz;
  assign sec_w = tx_highway_secondary_oe_out ? tx_highway_secondary_out : 1'bz;
  assign rx_frame_sync_in = tx_frame_sync_in;
  thsm_hwy_partner u_bp (
    .pri_in(pri_w),
    .sec_in(sec_w),
    .hclk_out(highway_clock_in),
    .fs_out(tx_frame_sync_in),
    .rxp_out(rx_highway_primary_in),
    .rxs_out(rx_highway_secondary_in)
  );
  thsm_slot_mapper u_dut (.*);
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (line_rx_vld_out === 1'b1) begin
      rxw[line_rx_chan_out] <= line_rx_word_out;
    end
  end
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    reg_wr_in = 1'b1;
    reg_idx_in = a;
    reg_wdata_in = d;
    @(posedge clk_in);
    #1;
    reg_wr_in = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_in);
    #1;
    reg_rd_in = 1'b1;
    reg_idx_in = a;
    @(posedge clk_in);
    #1;
    reg_rd_in = 1'b0;
    rd_v = reg_rdata_out;
  endtask
  task automatic wait_pos(input int p);
    int k;
    k = 0;
    while (u_bp.pos != p && k < 6000) begin
      @(posedge clk_in);
      k++;
    end
    if (k >= 6000) begin
      num_errors++;
      $display("BAD t=%0t pos=%h exp=%h", $time, u_bp.pos, p);
      conclude();
    end
  endtask
  // The first frame after a change may be partial, so the second is judged.
  // A rising launch edge puts every transmit bit one highway clock later.
  task automatic chk_frame(input logic on, input int sh);
    logic [7:0] gp, gs, ep, es;
    logic [15:0] ew;
    int s, b;
    for (s = 0; s < 2; s++) begin
      wait_pos(1);
      wait_pos(298);
    end
    for (s = 0; s < 9; s++) begin
      for (b = 0; b < 8; b++) begin
        gp[7 - b] = u_bp.cap_p[DT + 3 + sh + s * 8 + b];
        gs[7 - b] = u_bp.cap_s[DT + 3 + sh + s * 8 + b];
      end
      ep = (on && TEN[s] && !TSEL[s]) ? 8'h30 + 8'(s) : 8'hzz;
      es = (on && TEN[s] && TSEL[s]) ? 8'h30 + 8'(s) : 8'hzz;
      chk({8'h00, gp}, {8'h00, ep});
      chk({8'h00, gs}, {8'h00, es});
      ew = 16'h7e7e;
      if (on && s < 8 && REN[s]) begin
        ew = {(RSEL[s] ? 8'hc3 : 8'h5a) ^ 8'(s), 8'h00};
      end
      if (s < 8) begin
        chk(rxw[s], ew);
      end
    end
  endtask
  task automatic test_regs();
    int i;
    for (i = 0; i < 25; i++) begin
      rd(5'(i));
      chk({8'h00, rd_v}, 16'h0000);
      wr(5'(i), 8'(i) ^ 8'h5c);
      rd(5'(i));
      chk({8'h00, rd_v}, {8'h00, 8'(i) ^ 8'h5c});
      wr(5'(i), 8'h00);
    end
    rd(5'h1a);
    chk({8'h00, rd_v}, 16'h0000);
    // A write while the clock enable is low must leave the register alone.
    ce_in = 1'b0;
    wr(5'h00, 8'h11);
    ce_in = 1'b1;
    rd(5'h00);
    chk({8'h00, rd_v}, 16'h0000);
    $display("test_regs done");
  endtask
  task automatic test_off();
    int i;
    wr(5'h02, 8'hab);
    wr(5'h03, 8'h01);
    wr(5'h05, 8'hf5);
    wr(5'h09, 8'h0f);
    wr(5'h0d, 8'hf0);
    wr(5'h11, 8'h0a);
    wr(5'h18, 8'h7e);
    for (i = 0; i < 9; i++) begin
      @(posedge clk_in);
      #1;
      line_tx_wr_in = 1'b1;
      line_tx_chan_in = 5'(i);
      line_tx_word_in = {8'h30 + 8'(i), 8'h00};
    end
    @(posedge clk_in);
    #1;
    line_tx_wr_in = 1'b0;
    chk_frame(1'b0, 0);
    $display("test_off done");
  endtask
  task automatic test_on();
    // Narrow slots at the base rate keep the host limits.
    wr(5'h17, 8'h80);
    chk_frame(1'b1, 0);
    $display("test_on done");
  endtask
  task automatic test_edge();
    wr(5'h03, 8'h41);
    chk_frame(1'b1, 1);
    $display("test_edge done");
  endtask
  initial begin
    sys_rst_in = 1'b1;
    ce_in = 1'b1;
    reg_idx_in = 5'h00;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    line_tx_wr_in = 1'b0;
    line_tx_chan_in = 5'h00;
    line_tx_word_in = 16'h0000;
    // The link reset needs several slow clock edges to be seen.
    repeat (60) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    test_regs();
    test_off();
    test_on();
    test_edge();
    conclude();
  end
endmodule
bind thsm_slot_mapper thsm_chk u_chk (.*);

// ### verification/thsm_hwy_partner.sv
`timescale 1ns/1ps
module thsm_hwy_partner #(
  parameter int LEN = 300,
  parameter int RXD = 3
) (
  input wire logic pri_in,
  input wire logic sec_in,
  output logic hclk_out,
  output logic fs_out,
  output logic rxp_out,
  output logic rxs_out
);
  int pos;
  int j;
  logic cap_p [0:LEN-1];
  logic cap_s [0:LEN-1];
  function automatic logic pat(input int k, input logic sec);
    logic [7:0] b;
    b = (sec ? 8'hc3 : 8'h5a) ^ 8'(k / 8);
    return b[7 - k % 8];
  endfunction
  initial begin
    hclk_out = 1'b0;
    fs_out = 1'b0;
    rxp_out = 1'b0;
    rxs_out = 1'b1;
    pos = 0;
    #7;
    forever #32 hclk_out = ~hclk_out;
  end
  // Sync moves on the falling edge so a rising sample finds it settled.
  always @(negedge hclk_out) begin
    fs_out <= (pos == LEN - 1);
  end
  // Outside the frame the lines toggle, so stale data cannot pass.
  always @(posedge hclk_out) begin
    j = pos - RXD;
    cap_p[pos] <= pri_in;
    cap_s[pos] <= sec_in;
    if (j >= 0 && j < 256) begin
      rxp_out <= pat(j, 1'b0);
      rxs_out <= pat(j, 1'b1);
    end else begin
      rxp_out <= ~rxp_out;
      rxs_out <= ~rxs_out;
    end
    pos <= (pos == LEN - 1) ? 0 : pos + 1;
  end
endmodule

// ### verification/thsm_slot_mapper_assertions.sv
`timescale 1ns/1ps
module thsm_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic [4:0] reg_idx_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic line_rx_vld_out,
  input wire logic [15:0] line_rx_word_out,
  input wire logic highway_clock_in,
  input wire logic tx_highway_primary_oe_out,
  input wire logic tx_highway_secondary_oe_out
);
  logic wv_r;
  logic en_r;
  logic [4:0] wi_r;
  logic [7:0] wd_r;
  logic [7:0] off_r;
  // Off time is counted long enough for the enable to cross to the link.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wv_r <= 1'b0;
      en_r <= 1'b0;
      wi_r <= 5'h00;
      wd_r <= 8'h00;
      off_r <= 8'h00;
    end else begin
      if (ce_in && reg_wr_in && reg_idx_in < 5'h19) begin
        wv_r <= 1'b1;
        wi_r <= reg_idx_in;
        wd_r <= reg_wdata_in;
      end
      if (ce_in && reg_wr_in && reg_idx_in == 5'h17) begin
        en_r <= reg_wdata_in[7];
      end
      if (en_r) begin
        off_r <= 8'h00;
      end else if (off_r != 8'hff) begin
        off_r <= off_r + 8'h01;
      end
    end
  end
  a_wr_read: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    ce_in && reg_rd_in && !reg_wr_in && wv_r && reg_idx_in == wi_r
    |=> reg_rdata_out == $past(wd_r))
    else $error("read data differs from last write");
  a_rd_hold: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    !(ce_in && reg_rd_in) |=> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  a_no_map: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    ce_in && reg_rd_in && reg_idx_in > 5'h19 |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_rx_pulse: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    line_rx_vld_out |=> !line_rx_vld_out [*8])
    else $error("slot words closer than one slot");
  a_rx_hold: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    !line_rx_vld_out |-> $stable(line_rx_word_out))
    else $error("line word moved without valid");
  a_off_float: assert property (@(posedge clk_in)
    disable iff (sys_rst_in)
    off_r > 8'hc8 |->
    !tx_highway_primary_oe_out && !tx_highway_secondary_oe_out)
    else $error("highway driven while disabled");
  a_port_excl: assert property (@(posedge highway_clock_in)
    disable iff (sys_rst_in)
    !(tx_highway_primary_oe_out && tx_highway_secondary_oe_out))
    else $error("both transmit ports driven");
  a_gap_len: assert property (@(posedge highway_clock_in)
    disable iff (sys_rst_in)
    $fell(tx_highway_primary_oe_out) |-> !tx_highway_primary_oe_out [*8])
    else $error("float interval shorter than a slot");
endmodule
